// file: common/cnis_pkg.sv
package cnis_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int AW = 8;
  localparam int DW = 16;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [AW-1:0] STATUS_ADDR = 8'h00;
  localparam logic [AW-1:0] MASK_ADDR   = 8'h01;
  localparam logic [AW-1:0] CTRL_ADDR   = 8'h02;

  // ----------------------------------------
  // Status and control field positions
  // ----------------------------------------
  localparam int FAULT_BIT    = 15;
  localparam int CARD_IRQ_BIT = 8;
  localparam int REMOVED_BIT  = 7;
  localparam int INSERTED_BIT = 6;
  localparam int RD_RDY_BIT   = 5;
  localparam int WR_RDY_BIT   = 4;
  localparam int DMA_BIT      = 3;
  localparam int CTRL_WIDE_BIT = 0;

  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [DW-1:0] W1C_MASK     = 16'h00f8;
  localparam logic [DW-1:0] RSVD_MASK    = 16'h7e00;
  localparam logic [DW-1:0] STATUS_RESET = 16'h0000;
  localparam logic [DW-1:0] MASK_RESET   = 16'h0000;
  localparam logic [DW-1:0] CTRL_RESET   = 16'h0000;
  localparam logic          SYNC_RESET   = 1'b1;

endpackage

// file: common/cnis_irq_if.sv
`timescale 1ns/1ps
interface cnis_irq_if;
  logic sample_en;
  logic wide_mode;
  logic irq_window;
  logic card_irq;

  // Status side drives mode and gating
  modport ctl (output sample_en, output wide_mode, output irq_window, input card_irq);
  // Sampler side returns the card interrupt level
  modport smp (input sample_en, input wide_mode, input irq_window, output card_irq);
endinterface

// file: hw/cnis_card_irq_sampler.sv
`timescale 1ns/1ps
module cnis_card_irq_sampler (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  // Card data line 1, active low interrupt
  input  wire logic card_dat1_in,
  // Link to the status register
  cnis_irq_if.smp   bus
);

  logic dat_meta_q;
  logic dat_sync_q;
  logic card_irq_q;
  wire  take_sample;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Idle line is high, so reset to high
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      dat_meta_q <= cnis_pkg::SYNC_RESET;
      dat_sync_q <= cnis_pkg::SYNC_RESET;
    end else begin
      dat_meta_q <= card_dat1_in;
      dat_sync_q <= dat_meta_q;
    end
  end

  // ----------------------------------------
  // Sampling gate
  // ----------------------------------------
  // Narrow bus: watch every cycle while enabled, no card clock needed
  // Wide bus: only inside the interrupt cycle
  assign take_sample = bus.sample_en && (!bus.wide_mode || bus.irq_window);

  // Flag follows the card source; no write path
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      card_irq_q <= 1'b0;
    end else if (take_sample) begin
      card_irq_q <= ~dat_sync_q;
    end
  end

  assign bus.card_irq = card_irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_quiet;
    !sys_rst_in [*4];
  endsequence

  sequence s_narrow;
    bus.sample_en && !bus.wide_mode;
  endsequence

  property p_card_ro;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(card_irq_q) |-> $past(dat_sync_q) && $past(bus.sample_en);
  endproperty
  a_card_ro: assert property (p_card_ro) else $error("card flag cleared without source");

  property p_narrow_follow;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (s_quiet ##0 s_narrow) |=> card_irq_q == !$past(card_dat1_in, 3);
  endproperty
  a_narrow_follow: assert property (p_narrow_follow) else $error("narrow mode missed line");

  property p_wide_window;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (bus.wide_mode && !bus.irq_window) |=> $stable(card_irq_q);
  endproperty
  a_wide_window: assert property (p_wide_window) else $error("wide mode sampled outside");

endmodule

// file: hw/cnis_normal_status.sv
`timescale 1ns/1ps
module cnis_normal_status (
  // Clock and resets
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   por_rst_in,
  // Register port
  input  wire logic [cnis_pkg::AW-1:0] reg_addr_in,
  input  wire logic [cnis_pkg::DW-1:0] reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [cnis_pkg::DW-1:0] reg_rdata_out,
  // Fault status from the error register
  input  wire logic [cnis_pkg::DW-1:0] fault_event_status_in,
  // Card detect and card bus
  input  wire logic                   card_present_state_in,
  input  wire logic                   card_dat1_in,
  input  wire logic                   irq_window_in,
  // Buffer and DMA state
  input  wire logic                   read_buffer_enable_state_in,
  input  wire logic                   write_buffer_enable_state_in,
  input  wire logic                   dma_boundary_in,
  input  wire logic                   xfer_complete_in,
  input  wire logic                   xfer_start_in,
  // Interrupt
  output logic                        irq_out
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [cnis_pkg::DW-1:0] sticky_q;
  logic [cnis_pkg::DW-1:0] sticky_d;
  logic [cnis_pkg::DW-1:0] mask_q;
  logic                    wide_q;
  logic                    cp_meta_q;
  logic                    cp_sync_q;
  logic                    cp_prev_q;
  logic                    rbe_prev_q;
  logic                    wbe_prev_q;
  logic                    xfer_done_q;
  logic [cnis_pkg::DW-1:0] rdata_q;
  logic                    irq_q;

  cnis_irq_if ci ();

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire                    hit_status;
  wire                    hit_mask;
  wire                    hit_ctrl;
  wire                    wr_status;
  wire                    wr_mask;
  wire                    wr_ctrl;
  wire [cnis_pkg::DW-1:0] clr_vec;
  wire [cnis_pkg::DW-1:0] ctrl_view;

  assign hit_status = (reg_addr_in == cnis_pkg::STATUS_ADDR);
  assign hit_mask   = (reg_addr_in == cnis_pkg::MASK_ADDR);
  assign hit_ctrl   = (reg_addr_in == cnis_pkg::CTRL_ADDR);
  assign wr_status  = reg_wr_in && hit_status;
  assign wr_mask    = reg_wr_in && hit_mask;
  assign wr_ctrl    = reg_wr_in && hit_ctrl;

  // Only the write-one-to-clear bits can be hit
  assign clr_vec = wr_status ? (reg_wdata_in & cnis_pkg::W1C_MASK) : '0;

  assign ctrl_view = {{(cnis_pkg::DW-1){1'b0}}, wide_q};

  // ----------------------------------------
  // Card detect path
  // ----------------------------------------
  // Own reset so a controller reset never replays
  // an insert or remove edge already seen
  always_ff @(posedge clk_sys_in) begin
    if (por_rst_in) begin
      cp_meta_q <= 1'b0;
      cp_sync_q <= 1'b0;
      cp_prev_q <= 1'b0;
    end else begin
      cp_meta_q <= card_present_state_in;
      cp_sync_q <= cp_meta_q;
      cp_prev_q <= cp_sync_q;
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  wire                    ev_insert;
  wire                    ev_remove;
  wire                    ev_rd_rdy;
  wire                    ev_wr_rdy;
  wire                    ev_dma;
  wire [cnis_pkg::DW-1:0] ev_vec;

  // Edges only; a settled line gives none, each bounce gives one
  assign ev_insert = cp_sync_q && !cp_prev_q;
  assign ev_remove = !cp_sync_q && cp_prev_q;
  assign ev_rd_rdy = read_buffer_enable_state_in && !rbe_prev_q;
  assign ev_wr_rdy = write_buffer_enable_state_in && !wbe_prev_q;

  // Boundary in the completing cycle is dropped too
  assign ev_dma = dma_boundary_in && !xfer_done_q && !xfer_complete_in;

  assign ev_vec = (16'h0001 << cnis_pkg::REMOVED_BIT) & {cnis_pkg::DW{ev_remove}}
                | (16'h0001 << cnis_pkg::INSERTED_BIT) & {cnis_pkg::DW{ev_insert}}
                | (16'h0001 << cnis_pkg::RD_RDY_BIT) & {cnis_pkg::DW{ev_rd_rdy}}
                | (16'h0001 << cnis_pkg::WR_RDY_BIT) & {cnis_pkg::DW{ev_wr_rdy}}
                | (16'h0001 << cnis_pkg::DMA_BIT) & {cnis_pkg::DW{ev_dma}};

  // Set beats clear when both land in one cycle
  assign sticky_d = ((sticky_q & ~clr_vec) | ev_vec) & cnis_pkg::W1C_MASK;

  // ----------------------------------------
  // Previous levels and transfer state
  // ----------------------------------------
  // Start wins so a new transfer can raise DMA again
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rbe_prev_q  <= 1'b0;
      wbe_prev_q  <= 1'b0;
      xfer_done_q <= 1'b0;
    end else begin
      rbe_prev_q  <= read_buffer_enable_state_in;
      wbe_prev_q  <= write_buffer_enable_state_in;
      if (xfer_start_in) begin
        xfer_done_q <= 1'b0;
      end else if (xfer_complete_in) begin
        xfer_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Sticky flags, mask and control
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sticky_q <= cnis_pkg::STATUS_RESET;
      mask_q   <= cnis_pkg::MASK_RESET;
      wide_q   <= cnis_pkg::CTRL_RESET[cnis_pkg::CTRL_WIDE_BIT];
    end else begin
      sticky_q <= sticky_d;
      if (wr_mask) begin
        mask_q <= reg_wdata_in & ~cnis_pkg::RSVD_MASK;
      end
      if (wr_ctrl) begin
        wide_q <= reg_wdata_in[cnis_pkg::CTRL_WIDE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Card interrupt sampler
  // ----------------------------------------
  // Clearing the enable freezes the flag, so the
  // request drops through the mask while serviced
  assign ci.sample_en  = mask_q[cnis_pkg::CARD_IRQ_BIT];
  assign ci.wide_mode  = wide_q;
  assign ci.irq_window = irq_window_in;

  cnis_card_irq_sampler u_sampler (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .card_dat1_in (card_dat1_in),
    .bus          (ci.smp)
  );

  // ----------------------------------------
  // Read view and interrupt
  // ----------------------------------------
  wire                    fault_any;
  wire [cnis_pkg::DW-1:0] status_view;
  wire [cnis_pkg::DW-1:0] rd_mux;

  assign fault_any = |fault_event_status_in;

  // Reserved bits never get a source
  assign status_view = sticky_q
                     | ({{(cnis_pkg::DW-1){1'b0}}, ci.card_irq} << cnis_pkg::CARD_IRQ_BIT)
                     | ({{(cnis_pkg::DW-1){1'b0}}, fault_any} << cnis_pkg::FAULT_BIT);

  assign rd_mux = hit_status ? status_view :
                  hit_mask   ? mask_q      :
                  hit_ctrl   ? ctrl_view   : '0;

  // Data registered so it stands the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : '0;
      irq_q   <= |(status_view & mask_q);
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out       = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_status_read;
    reg_rd_in && hit_status;
  endsequence

  property p_fault_sum;
    s_status_read |=> reg_rdata_out[cnis_pkg::FAULT_BIT] == $past(fault_any);
  endproperty
  a_fault_sum: assert property (p_fault_sum) else $error("summary bit wrong");

  property p_removed_set;
    (cp_prev_q && !cp_sync_q) |=> sticky_q[cnis_pkg::REMOVED_BIT];
  endproperty
  a_removed_set: assert property (p_removed_set) else $error("removal not flagged");

  property p_inserted_set;
    (!cp_prev_q && cp_sync_q) |=> sticky_q[cnis_pkg::INSERTED_BIT];
  endproperty
  a_inserted_set: assert property (p_inserted_set) else $error("insertion not flagged");

  property p_w1c_clear;
    (wr_status && reg_wdata_in[cnis_pkg::INSERTED_BIT] && !ev_insert)
      |=> !sticky_q[cnis_pkg::INSERTED_BIT];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

  property p_w0_keep;
    (wr_status && !reg_wdata_in[cnis_pkg::REMOVED_BIT] && sticky_q[cnis_pkg::REMOVED_BIT])
      |=> sticky_q[cnis_pkg::REMOVED_BIT];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero cleared a flag");

  property p_detect_quiet;
    $rose(sticky_q[cnis_pkg::INSERTED_BIT]) |-> $past(cp_sync_q) && !$past(cp_prev_q);
  endproperty
  a_detect_quiet: assert property (p_detect_quiet) else $error("insert flag without edge");

  property p_rd_rdy;
    $rose(read_buffer_enable_state_in) |=> sticky_q[cnis_pkg::RD_RDY_BIT];
  endproperty
  a_rd_rdy: assert property (p_rd_rdy) else $error("read ready missed");

  property p_wr_rdy;
    (write_buffer_enable_state_in && !wbe_prev_q) |=> sticky_q[cnis_pkg::WR_RDY_BIT];
  endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("write ready missed");

  property p_dma_set;
    (dma_boundary_in && !xfer_done_q && !xfer_complete_in) |=> sticky_q[cnis_pkg::DMA_BIT];
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("boundary not flagged");

  property p_dma_after_done;
    $rose(sticky_q[cnis_pkg::DMA_BIT]) |-> !$past(xfer_done_q) && !$past(xfer_complete_in);
  endproperty
  a_dma_after_done: assert property (p_dma_after_done) else $error("DMA after complete");

  property p_detect_survives;
    disable iff (por_rst_in) sys_rst_in |=> cp_prev_q == $past(cp_sync_q);
  endproperty
  a_detect_survives: assert property (p_detect_survives) else $error("detect reset");

  property p_reserved_zero;
    s_status_read |=> reg_rdata_out[14:9] == 6'h00 && reg_rdata_out[2:0] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_irq_level;
    ##1 irq_out == |$past(status_view & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // Removed flag clears on a written one unless a new removal lands
  property p_w1c_removed;
    (wr_status && reg_wdata_in[cnis_pkg::REMOVED_BIT] && !ev_remove)
      |=> !sticky_q[cnis_pkg::REMOVED_BIT];
  endproperty
  a_w1c_removed: assert property (p_w1c_removed) else $error("removed flag kept");

  // Read data stands one cycle only, then drops back to zero
  property p_rdata_idle;
    !reg_rd_in |=> reg_rdata_out == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

endmodule

// file: tb/cnis_card_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Removable card on the card bus
// ----------------------------------------
module cnis_card_model (
  // Clock
  input  wire logic clk_sys_in,
  // Card pins seen by the host
  output logic      card_present_out,
  output logic      card_dat1_out
);
  // Card absent at start; pulled-up DAT1 idles high
  initial begin
    card_present_out = 1'b0;
    card_dat1_out    = 1'b1;
  end

  // Seat or pull the card, level already debounced
  task automatic set_present(input logic level);
    @(posedge clk_sys_in);
    card_present_out <= level;
  endtask

  // Raise or drop the card's own interrupt source, low active
  task automatic set_irq(input logic active);
    @(posedge clk_sys_in);
    card_dat1_out <= ~active;
  endtask
endmodule

// file: tb/card_host_normal_irq_status_tb.sv
`timescale 1ns/1ps
module card_host_normal_irq_status_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                    clk_sys_in = 1'b0;
  logic                    sys_rst_in = 1'b1;
  logic                    por_rst_in = 1'b1;
  logic [cnis_pkg::AW-1:0] reg_addr_in = 8'h00;
  logic [cnis_pkg::DW-1:0] reg_wdata_in = 16'h0000;
  logic                    reg_wr_in = 1'b0;
  logic                    reg_rd_in = 1'b0;
  logic [cnis_pkg::DW-1:0] reg_rdata_out;
  logic [cnis_pkg::DW-1:0] fault_in = 16'h0000;
  logic                    present;
  logic                    dat1;
  logic                    window = 1'b0;
  logic                    rbe = 1'b0;
  logic                    wbe = 1'b0;
  logic [2:0]              ev = 3'h0;
  logic                    irq_out;
  int                      fail_count = 0;
  int                      num_checks = 0;

  // 100 ns clock
  always #50 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------
  // Block and card
  // ----------------------------------------
  cnis_normal_status dut_u (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .por_rst_in(por_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .fault_event_status_in(fault_in), .card_present_state_in(present),
    .card_dat1_in(dat1), .irq_window_in(window),
    .read_buffer_enable_state_in(rbe), .write_buffer_enable_state_in(wbe),
    .dma_boundary_in(ev[0]), .xfer_complete_in(ev[1]), .xfer_start_in(ev[2]),
    .irq_out(irq_out));

  cnis_card_model card_u (
    .clk_sys_in(clk_sys_in), .card_present_out(present), .card_dat1_out(dat1));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  // Read data is taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk_word(d, exp);
  endtask

  // Synchronised inputs: read status until the bit settles, bounded
  task automatic poll(input int b, input logic e);
    logic [15:0] d;
    int n;
    n = 0;
    rd(cnis_pkg::STATUS_ADDR, d);
    while (d[b] !== e && n < 10) begin
      rd(cnis_pkg::STATUS_ADDR, d);
      n++;
    end
    chk_bit(d[b], e);
    if (d[b] !== e) give_verdict();
  endtask

  // One-cycle pulse on an event input
  task automatic pulse(input int i);
    @(posedge clk_sys_in);
    ev[i] <= 1'b1;
    @(posedge clk_sys_in);
    ev[i] <= 1'b0;
  endtask

  // Level inputs move together right after an edge, so no edge sees some changed and others not
  task automatic levels(input logic [15:0] f, input logic w, input logic r, input logic b);
    @(posedge clk_sys_in);
    fault_in <= f;
    window   <= w;
    rbe      <= r;
    wbe      <= b;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    rd_chk(cnis_pkg::MASK_ADDR, 16'h0000);
    rd_chk(cnis_pkg::CTRL_ADDR, 16'h0000);
    wr(8'h05, 16'hffff);
    rd_chk(8'h05, 16'h0000);
    chk_bit(irq_out, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_detect();
    wr(cnis_pkg::MASK_ADDR, 16'h0040);
    card_u.set_present(1'b1);
    poll(cnis_pkg::INSERTED_BIT, 1'b1);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0040);
    chk_bit(irq_out, 1'b1);
    wr(cnis_pkg::STATUS_ADDR, 16'h0000);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0040);
    wr(cnis_pkg::STATUS_ADDR, 16'h0040);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    chk_bit(irq_out, 1'b0);
    card_u.set_present(1'b0);
    poll(cnis_pkg::REMOVED_BIT, 1'b1);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0080);
    chk_bit(irq_out, 1'b0);
    wr(cnis_pkg::STATUS_ADDR, 16'h0040);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0080);
    wr(cnis_pkg::STATUS_ADDR, 16'h0080);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    wr(cnis_pkg::MASK_ADDR, 16'h0000);
    $display("test detect done");
  endtask

  // Levels stay high after clearing: only a new rise may set again
  task automatic t_buffer();
    levels(16'h0000, 1'b0, 1'b1, 1'b0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0020);
    levels(16'h0000, 1'b0, 1'b1, 1'b1);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0030);
    wr(cnis_pkg::STATUS_ADDR, 16'h0020);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0010);
    wr(cnis_pkg::STATUS_ADDR, 16'hffff);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    levels(16'h0000, 1'b0, 1'b0, 1'b0);
    $display("test buffer done");
  endtask

  task automatic t_dma();
    pulse(0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0008);
    wr(cnis_pkg::STATUS_ADDR, 16'h0008);
    pulse(1);
    pulse(0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    pulse(2);
    pulse(0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0008);
    wr(cnis_pkg::STATUS_ADDR, 16'h0008);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    $display("test dma done");
  endtask

  task automatic t_fault();
    levels(16'h0100, 1'b0, 1'b0, 1'b0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h8000);
    wr(cnis_pkg::STATUS_ADDR, 16'h8000);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h8000);
    levels(16'h0001, 1'b0, 1'b0, 1'b0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h8000);
    levels(16'h0000, 1'b0, 1'b0, 1'b0);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    $display("test fault done");
  endtask

  task automatic t_card_irq();
    wr(cnis_pkg::MASK_ADDR, 16'h0100);
    card_u.set_irq(1'b1);
    poll(cnis_pkg::CARD_IRQ_BIT, 1'b1);
    wr(cnis_pkg::STATUS_ADDR, 16'h0100);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0100);
    chk_bit(irq_out, 1'b1);
    wr(cnis_pkg::MASK_ADDR, 16'h0000);
    rd_chk(cnis_pkg::MASK_ADDR, 16'h0000);
    chk_bit(irq_out, 1'b0);
    card_u.set_irq(1'b0);
    repeat (8) @(posedge clk_sys_in);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0100);
    wr(cnis_pkg::MASK_ADDR, 16'h0100);
    poll(cnis_pkg::CARD_IRQ_BIT, 1'b0);
    wr(cnis_pkg::CTRL_ADDR, 16'h0001);
    card_u.set_irq(1'b1);
    repeat (8) @(posedge clk_sys_in);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    levels(16'h0000, 1'b1, 1'b0, 1'b0);
    poll(cnis_pkg::CARD_IRQ_BIT, 1'b1);
    card_u.set_irq(1'b0);
    poll(cnis_pkg::CARD_IRQ_BIT, 1'b0);
    levels(16'h0000, 1'b0, 1'b0, 1'b0);
    wr(cnis_pkg::CTRL_ADDR, 16'h0000);
    wr(cnis_pkg::MASK_ADDR, 16'h0000);
    $display("test card irq done");
  endtask

  // Controller reset must not replay the insert through the detect chain
  task automatic t_ctl_reset();
    card_u.set_present(1'b1);
    poll(cnis_pkg::INSERTED_BIT, 1'b1);
    wr(cnis_pkg::MASK_ADDR, 16'h00f8);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rd_chk(cnis_pkg::STATUS_ADDR, 16'h0000);
    rd_chk(cnis_pkg::MASK_ADDR, 16'h0000);
    chk_bit(irq_out, 1'b0);
    card_u.set_present(1'b0);
    poll(cnis_pkg::REMOVED_BIT, 1'b1);
    wr(cnis_pkg::STATUS_ADDR, 16'h0080);
    $display("test controller reset done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    por_rst_in <= 1'b0;
    t_reset();
    t_detect();
    t_buffer();
    t_dma();
    t_fault();
    t_card_irq();
    t_ctl_reset();
    give_verdict();
  end
endmodule
